// >>> src/tcr_cal_regs.sv
// Touch calibration point register bank with dot position calculator
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module tcr_cal_regs (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // APB slave
   input wire tcr_pkg::tcr_apb_req_t apb_req,
   output var tcr_pkg::tcr_apb_rsp_t apb_rsp,
   // Touch samples from the converter
   input wire tcr_pkg::tcr_touch_t touch_in,
   // Dot position result
   output logic [15:0] touch_x_dot,
   output logic calc_busy
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   // Dot order: A x, A y, B x, B y, C x, C y; raw order: A x, A y, B x
   typedef struct packed {
      logic [5:0][15:0] dot;
      logic [2:0][11:0] raw;
      logic [15:0] scale;
   } tcr_regs_t;

   tcr_regs_t regs_r;
   tcr_regs_t regs_nxt;
   logic [7:0] acc_idx;
   logic wr_stb;
   logic [15:0] wr_data;
   logic [15:0] rd_word;
   logic calc_start;

   // ----------------------------------------------------------------
   // Bus front end
   // ----------------------------------------------------------------
   tcr_apb_slave u_apb (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .apb_req(apb_req),
      .apb_rsp(apb_rsp),
      .acc_idx(acc_idx),
      .wr_stb(wr_stb),
      .wr_data(wr_data),
      .rd_word(rd_word)
   );

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   always_comb begin
      regs_nxt = regs_r;
      if (wr_stb) begin
         for (int i = 0; i < 6; i++) begin
            if (acc_idx == tcr_pkg::IDX_A_X_DOT +
                8'(i) * tcr_pkg::IDX_STEP) begin
               regs_nxt.dot[i] = wr_data;
            end
         end
         for (int j = 0; j < 3; j++) begin
            if (acc_idx == tcr_pkg::IDX_A_X_RAW +
                8'(j) * tcr_pkg::IDX_STEP) begin
               regs_nxt.raw[j] = wr_data[11:0];
            end
         end
         if (acc_idx == tcr_pkg::IDX_X_SCALE) begin
            regs_nxt.scale = wr_data;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         regs_r.dot <= {6{tcr_pkg::RST_DOT}};
         regs_r.raw <= {3{tcr_pkg::RST_RAW}};
         regs_r.scale <= tcr_pkg::RST_SCALE;
      end else begin
         regs_r <= regs_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Read mux, free of side effects
   // ----------------------------------------------------------------
   always_comb begin
      rd_word = 16'h0000;
      for (int i = 0; i < 6; i++) begin
         if (acc_idx == tcr_pkg::IDX_A_X_DOT +
             8'(i) * tcr_pkg::IDX_STEP) begin
            rd_word = regs_r.dot[i];
         end
      end
      for (int j = 0; j < 3; j++) begin
         if (acc_idx == tcr_pkg::IDX_A_X_RAW +
             8'(j) * tcr_pkg::IDX_STEP) begin
            rd_word = {4'h0, regs_r.raw[j]};
         end
      end
      if (acc_idx == tcr_pkg::IDX_X_SCALE) begin
         rd_word = regs_r.scale;
      end
      if (acc_idx == tcr_pkg::IDX_X_RESULT) begin
         rd_word = touch_x_dot;
      end
   end

   // ----------------------------------------------------------------
   // Dot position calculation
   // ----------------------------------------------------------------
   // Samples arriving while a calculation runs are not queued
   assign calc_start = touch_in.valid && !calc_busy &&
      regs_r.scale != 16'h0000;

   tcr_dot_calc u_calc (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .start(calc_start),
      .raw(touch_in.x_raw),
      .a_raw(regs_r.raw[0]),
      .a_dot(regs_r.dot[0]),
      .scale(regs_r.scale),
      .busy(calc_busy),
      .result(touch_x_dot)
   );

endmodule : tcr_cal_regs
`default_nettype wire

// >>> shared/tcr_pkg.sv
// Shared constants, carriers and decode for the calibration register bank
`default_nettype none
package tcr_pkg;

   // -----------------------------------------------------------------
   // Widths
   // -----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int REG_W = 16;
   localparam int RAW_W = 12;
   localparam int PROD_W = 28;

   // -----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // -----------------------------------------------------------------
   localparam logic [7:0] IDX_X_RESULT = 8'h28;
   localparam logic [7:0] IDX_A_X_DOT = 8'h2c;
   localparam logic [7:0] IDX_A_Y_DOT = 8'h2e;
   localparam logic [7:0] IDX_B_X_DOT = 8'h30;
   localparam logic [7:0] IDX_B_Y_DOT = 8'h32;
   localparam logic [7:0] IDX_C_X_DOT = 8'h34;
   localparam logic [7:0] IDX_C_Y_DOT = 8'h36;
   localparam logic [7:0] IDX_A_X_RAW = 8'h38;
   localparam logic [7:0] IDX_A_Y_RAW = 8'h3a;
   localparam logic [7:0] IDX_B_X_RAW = 8'h3c;
   localparam logic [7:0] IDX_X_SCALE = 8'h44;
   localparam logic [7:0] IDX_STEP = 8'h02;

   // -----------------------------------------------------------------
   // Reset values and arithmetic constants
   // -----------------------------------------------------------------
   localparam logic [15:0] RST_DOT = 16'h0000;
   localparam logic [11:0] RST_RAW = 12'h000;
   localparam logic [15:0] RST_SCALE = 16'h0000;
   localparam logic [15:0] RST_RESULT = 16'h0000;
   localparam logic [9:0] SCALE_DIVISOR = 10'h3e8;
   localparam logic [4:0] DIV_STEPS = 5'h1c;

   // -----------------------------------------------------------------
   // Carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } tcr_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } tcr_apb_rsp_t;

   typedef struct packed {
      logic valid;
      logic [11:0] x_raw;
   } tcr_touch_t;

   typedef enum logic [0:0] {
      TCR_IDLE = 1'b0,
      TCR_DIV = 1'b1
   } tcr_calc_st_t;

   // -----------------------------------------------------------------
   // Address decode
   // -----------------------------------------------------------------
   function automatic logic [7:0] reg_index(input logic [11:0] paddr);
      return paddr[9:2];
   endfunction : reg_index

   function automatic logic reg_mapped(input logic [11:0] paddr);
      logic [7:0] idx;
      idx = paddr[9:2];
      if (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0) begin
         return 1'b0;
      end
      return idx == IDX_X_RESULT || idx == IDX_X_SCALE ||
         (idx >= IDX_A_X_DOT && idx <= IDX_B_X_RAW && !idx[0]);
   endfunction : reg_mapped

endpackage : tcr_pkg
`default_nettype wire

// >>> src/tcr_apb_slave.sv
// APB slave front end: decode, strobes and registered read answer
`timescale 1ns/1ps
`default_nettype none
module tcr_apb_slave (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // APB
   input wire tcr_pkg::tcr_apb_req_t apb_req,
   output var tcr_pkg::tcr_apb_rsp_t apb_rsp,
   // Register file side
   output logic [7:0] acc_idx,
   output logic wr_stb,
   output logic [15:0] wr_data,
   input wire logic [15:0] rd_word
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0] prdata;
      logic err;
   } tcr_apb_st_t;

   tcr_apb_st_t st_r;
   tcr_apb_st_t st_nxt;
   logic setup;

   assign setup = apb_req.psel && !apb_req.penable;
   assign acc_idx = tcr_pkg::reg_index(apb_req.paddr);
   assign wr_data = apb_req.pwdata[15:0];
   // Write lands on the single access edge, only on a mapped word
   assign wr_stb = apb_req.psel && apb_req.penable && apb_req.pwrite &&
      !st_r.err;

   // Read word and error are captured in setup, shown in access
   always_comb begin
      st_nxt = st_r;
      if (setup) begin
         st_nxt.err = !tcr_pkg::reg_mapped(apb_req.paddr);
         st_nxt.prdata = 32'h0000_0000;
         if (!apb_req.pwrite && tcr_pkg::reg_mapped(apb_req.paddr)) begin
            st_nxt.prdata = {16'h0000, rd_word};
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && st_r.err;
   assign apb_rsp.prdata = st_r.prdata;

endmodule : tcr_apb_slave
`default_nettype wire

// >>> src/tcr_dot_calc.sv
// Horizontal dot position calculator: a_dot + (raw - a_raw) * scale / 1000
`timescale 1ns/1ps
`default_nettype none
module tcr_dot_calc (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Request
   input wire logic start,
   input wire logic [11:0] raw,
   input wire logic [11:0] a_raw,
   input wire logic [15:0] a_dot,
   input wire logic [15:0] scale,
   // Result
   output logic busy,
   output logic [15:0] result
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      tcr_pkg::tcr_calc_st_t st;
      logic [4:0] cnt;
      logic neg;
      logic [10:0] rem;
      logic [27:0] quo;
      logic [15:0] base;
      logic [15:0] result;
   } tcr_calc_t;

   tcr_calc_t c_r;
   tcr_calc_t c_nxt;
   logic [12:0] diff;
   logic [11:0] mag;
   logic [10:0] trial;
   logic [27:0] q_signed;

   assign diff = {1'b0, raw} - {1'b0, a_raw};
   assign mag = diff[12] ? 12'(-diff) : diff[11:0];
   assign trial = {c_r.rem[9:0], c_r.quo[27]};

   // ----------------------------------------------------------------
   // Restoring division of the product magnitude by the divisor
   // ----------------------------------------------------------------
   always_comb begin
      c_nxt = c_r;
      case (c_r.st)
         tcr_pkg::TCR_IDLE: begin
            if (start) begin
               c_nxt.st = tcr_pkg::TCR_DIV;
               c_nxt.cnt = 5'h00;
               c_nxt.neg = diff[12];
               c_nxt.rem = 11'h000;
               c_nxt.quo = 28'(mag) * 28'(scale);
               c_nxt.base = a_dot;
            end
         end
         tcr_pkg::TCR_DIV: begin
            if (trial >= {1'b0, tcr_pkg::SCALE_DIVISOR}) begin
               c_nxt.rem = trial - {1'b0, tcr_pkg::SCALE_DIVISOR};
               c_nxt.quo = {c_r.quo[26:0], 1'b1};
            end else begin
               c_nxt.rem = trial;
               c_nxt.quo = {c_r.quo[26:0], 1'b0};
            end
            c_nxt.cnt = c_r.cnt + 5'h01;
            if (c_r.cnt == tcr_pkg::DIV_STEPS - 5'h01) begin
               c_nxt.st = tcr_pkg::TCR_IDLE;
            end
         end
         default: begin
            c_nxt.st = tcr_pkg::TCR_IDLE;
         end
      endcase
      q_signed = c_nxt.neg ? -c_nxt.quo : c_nxt.quo;
      // Last step: the quotient is complete in the next state
      if (c_r.st == tcr_pkg::TCR_DIV &&
          c_r.cnt == tcr_pkg::DIV_STEPS - 5'h01) begin
         c_nxt.result = c_r.base + q_signed[15:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         c_r <= '0;
      end else begin
         c_r <= c_nxt;
      end
   end

   assign busy = c_r.st == tcr_pkg::TCR_DIV;
   assign result = c_r.result;

endmodule : tcr_dot_calc
`default_nettype wire

// >>> bench/tcr_cal_regs_assertions.sv
// Port checks for the calibration register bank
`timescale 1ns/1ps
`default_nettype none
module tcr_cal_regs_assertions (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Watched ports
   input wire tcr_pkg::tcr_apb_req_t apb_req,
   input wire tcr_pkg::tcr_apb_rsp_t apb_rsp,
   input wire tcr_pkg::tcr_touch_t touch_in,
   input wire logic [15:0] touch_x_dot,
   input wire logic calc_busy
);
   logic wr;
   logic rd;
   logic [11:0] a;
   logic [15:0] d;
   logic [15:0] q;
   assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
   assign a = apb_req.paddr;
   assign d = apb_req.pwdata[15:0];
   assign q = apb_rsp.prdata[15:0];
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ----------
   // Read-back right after a write
   // ----------
   AST_DOT_A_X: assert property (wr && a == 12'h0b0 ##1 rd && a == 12'h0b0
      |=> q == $past(d, 2)) else $error("a x dot readback");
   AST_DOT_A_Y: assert property (wr && a == 12'h0b8 ##1 rd && a == 12'h0b8
      |=> q == $past(d, 2)) else $error("a y dot readback");
   AST_DOT_B_X: assert property (wr && a == 12'h0c0 ##1 rd && a == 12'h0c0
      |=> q == $past(d, 2)) else $error("b x dot readback");
   AST_DOT_B_Y: assert property (wr && a == 12'h0c8 ##1 rd && a == 12'h0c8
      |=> q == $past(d, 2)) else $error("b y dot readback");
   AST_RAW_A_X: assert property (wr && a == 12'h0e0 ##1 rd && a == 12'h0e0
      |=> q == ($past(d, 2) & 16'h0fff)) else $error("a x raw readback");
   AST_RAW_A_Y: assert property (wr && a == 12'h0e8 ##1 rd && a == 12'h0e8
      |=> q == ($past(d, 2) & 16'h0fff)) else $error("a y raw readback");
   AST_RAW_B_X: assert property (wr && a == 12'h0f0 ##1 rd && a == 12'h0f0
      |=> q == ($past(d, 2) & 16'h0fff)) else $error("b x raw readback");
   // ----------
   // Dot calculation timing
   // ----------
   AST_BUSY_LEN: assert property ($rose(calc_busy)
      |-> ##27 calc_busy ##1 !calc_busy) else $error("busy length");
   AST_BUSY_CAUSE: assert property ($rose(calc_busy)
      |-> $past(touch_in.valid)) else $error("busy without sample");
   AST_RESULT_HOLD: assert property ($changed(touch_x_dot)
      |-> $past(calc_busy) || $past(calc_busy, 2))
      else $error("result moved while idle");
endmodule : tcr_cal_regs_assertions
`default_nettype wire

// >>> bench/tcr_cal_regs_tb.sv
// Self-checking bench for the calibration register bank
`timescale 1ns/1ps
`default_nettype none
module tcr_cal_regs_tb;
   logic sys_clk;
   logic rst_n;
   tcr_pkg::tcr_apb_req_t apb_req;
   tcr_pkg::tcr_apb_rsp_t apb_rsp;
   tcr_pkg::tcr_touch_t touch_in;
   logic [15:0] touch_x_dot;
   logic calc_busy;
   int num_errors = 0;
   int n_tests = 0;
   int cyc_cnt = 0;
   logic [31:0] rdat;
   logic err;
   // Rows: address, write data, expected read-back; no point C words
   logic [11:0] row_a [7] = '{12'h0b0, 12'h0b8, 12'h0c0, 12'h0c8,
      12'h0e0, 12'h0e8, 12'h0f0};
   logic [15:0] row_w [7] = '{16'hffff, 16'h8001, 16'h5a5a, 16'ha5a5,
      16'hffff, 16'hf123, 16'h7abc};
   logic [15:0] row_e [7] = '{16'hffff, 16'h8001, 16'h5a5a, 16'ha5a5,
      16'h0fff, 16'h0123, 16'h0abc};

   tcr_cal_regs u_tcr_cal_regs (.sys_clk(sys_clk), .rst_n(rst_n),
      .apb_req(apb_req), .apb_rsp(apb_rsp), .touch_in(touch_in),
      .touch_x_dot(touch_x_dot), .calc_busy(calc_busy));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 5000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   // ----------
   // Tasks
   // ----------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic apb(input logic w, input logic [11:0] ad,
      input logic [31:0] wd);
      logic rdy;
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad,
         pwdata: wd};
      @(posedge sys_clk);
      apb_req.penable <= 1'b1;
      // Answer is read where it stands, ahead of the edge that ends it
      do begin
         @(negedge sys_clk);
         rdy = apb_rsp.pready;
         rdat = apb_rsp.prdata;
         err = apb_rsp.pslverr;
         @(posedge sys_clk);
      end while (rdy !== 1'b1);
   endtask : apb

   task automatic idle();
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      @(posedge sys_clk);
   endtask : idle

   task automatic check_zero();
      for (int i = 0; i < 7; i++) begin
         apb(1'b0, row_a[i], 32'h0);
         check(rdat, 32'h0);
      end
      idle();
      check({16'h0, touch_x_dot}, 32'h0);
   endtask : check_zero

   task automatic touch(input logic [11:0] raw);
      touch_in <= '{valid: 1'b1, x_raw: raw};
      @(posedge sys_clk);
      touch_in.valid <= 1'b0;
      repeat (2) @(posedge sys_clk);
      for (int k = 0; k < 60 && calc_busy; k++) @(posedge sys_clk);
      @(posedge sys_clk);
   endtask : touch

   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish

   // ----------
   // Sequence
   // ----------
   initial begin
      rst_n = 1'b0;
      apb_req = '0;
      touch_in = '0;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      check_zero();
      $display("Reset values done");
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, row_a[i], {16'hdead, row_w[i]});
         apb(1'b0, row_a[i], 32'h0);
         check(rdat, {16'h0, row_e[i]});
      end
      for (int i = 0; i < 7; i++) begin
         apb(1'b0, row_a[i], 32'h0);
         check(rdat, {16'h0, row_e[i]});
      end
      idle();
      $display("Register table done");
      apb(1'b0, 12'h0b4, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rdat, 32'h0);
      idle();
      $display("Unmapped access done");
      touch(12'h180);
      check({16'h0, touch_x_dot}, 32'h0);
      apb(1'b1, 12'h0b0, 32'h64);
      apb(1'b1, 12'h0e0, 32'h100);
      apb(1'b1, 12'h110, 32'h7d0);
      idle();
      touch(12'h180);
      check({16'h0, touch_x_dot}, 32'h164);
      touch(12'h080);
      check({16'h0, touch_x_dot}, 32'hff64);
      apb(1'b1, 12'h0a0, 32'h1234);
      apb(1'b0, 12'h0a0, 32'h0);
      check(rdat, 32'hff64);
      apb(1'b1, 12'h0b4, 32'hffff);
      check({31'h0, err}, 32'h1);
      apb(1'b0, 12'h0b0, 32'h0);
      check(rdat, 32'h64);
      idle();
      $display("Dot calculation done");
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      check_zero();
      $display("Second reset done");
      tally_and_finish();
   end
endmodule : tcr_cal_regs_tb

bind tcr_cal_regs tcr_cal_regs_assertions u_tcr_cal_regs_assertions (
   .sys_clk(sys_clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .touch_in(touch_in), .touch_x_dot(touch_x_dot), .calc_busy(calc_busy));
`default_nettype wire
